// >>> logic/nand_host.sv
// Host controller driving a small-page NAND flash through its strobes, set up by AXI4-Lite registers.
// What this block does
// - Three address cycles, top bit low
// - Upper byte low in address cycles
// - Latch lines classify each write cycle
// - Fixed command code set
// - Never send 01 to x16 variant
// - Commands on low byte, upper zero
// - Only status or reset while busy
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module nand_host #(
    parameter int WIDE = 0
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Flash pins
    output logic             chip_select_n,
    output logic             cmd_latch,
    output logic             addr_latch,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic             write_protect_n,
    output logic [15:0]      io_out,
    output logic             io_oe,
    input  wire logic [15:0] io_in,
    input  wire logic        ready_busy_n
);
    strobe_if sif ();

    logic [31:0] ctrl_reg;
    logic [31:0] addr_reg;
    logic [15:0] wdata_reg;
    logic        issue_reg;
    logic        refused_reg;
    logic        pend_reg;
    logic [1:0]  acnt_reg;
    logic        sent_reg;
    logic        dev_busy_reg;
    logic [7:0]  last_cmd_reg;

    logic        aw_take;
    logic        ar_take;
    logic [7:0]  code_w;
    nand_host_pkg::kind_t kind_w;
    logic        code_ok;
    logic        issue_ok;
    logic [31:0] rd_mux;
    logic        addr_hit;

    function automatic logic known_code(input logic [7:0] c);
        return c == nand_host_pkg::CMD_READ_FIRST  || c == nand_host_pkg::CMD_READ_SECOND ||
               c == nand_host_pkg::CMD_READ_SPARE  || c == nand_host_pkg::CMD_DATA_LOAD   ||
               c == nand_host_pkg::CMD_PROGRAM     || c == nand_host_pkg::CMD_ERASE_SETUP ||
               c == nand_host_pkg::CMD_ERASE_START || c == nand_host_pkg::CMD_STATUS      ||
               c == nand_host_pkg::CMD_IDENT       || c == nand_host_pkg::CMD_RESET;
    endfunction : known_code

    function automatic logic map_hit(input logic [4:0] a);
        return a == nand_host_pkg::REG_CTRL  || a == nand_host_pkg::REG_ADDR   ||
               a == nand_host_pkg::REG_WDATA || a == nand_host_pkg::REG_RDATA  ||
               a == nand_host_pkg::REG_STATUS;
    endfunction : map_hit

    assign code_w = ctrl_reg[nand_host_pkg::CTRL_CODE_LSB +: 8];
    assign kind_w = nand_host_pkg::kind_t'(ctrl_reg[nand_host_pkg::CTRL_KIND_LSB +: 2]);
    assign chip_select_n   = 1'b0;
    assign write_protect_n = ctrl_reg[nand_host_pkg::CTRL_WP_BIT];

    assign code_ok = known_code(code_w) && !(WIDE != 0 && code_w == nand_host_pkg::CMD_READ_SECOND) &&
                     (!(dev_busy_reg || !ready_busy_n) || code_w == nand_host_pkg::CMD_STATUS ||
                      code_w == nand_host_pkg::CMD_RESET);
    assign issue_ok = (kind_w != nand_host_pkg::KIND_CMD) || code_ok;

    // Both channels are taken together so a write never splits across two cycles.
    assign aw_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !pend_reg;
    assign s_axi_awready = aw_take;
    assign s_axi_wready  = aw_take;
    assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = ar_take;
    assign addr_hit      = map_hit(s_axi_awaddr);

    assign rd_mux = (s_axi_araddr == nand_host_pkg::REG_CTRL)   ? ctrl_reg :
                    (s_axi_araddr == nand_host_pkg::REG_ADDR)   ? addr_reg :
                    (s_axi_araddr == nand_host_pkg::REG_WDATA)  ? {16'h0000, wdata_reg} :
                    (s_axi_araddr == nand_host_pkg::REG_RDATA)  ? {16'h0000, sif.rdata} :
                    (s_axi_araddr == nand_host_pkg::REG_STATUS) ?
                        {22'h0, last_cmd_reg, refused_reg, ready_busy_n} : 32'h0000_0000;

    // Issue a cycle to the driver; address cycles send the byte chosen by the cycle counter.
    // A refused request must never reach the pins, so the screening gates the start as well.
    assign sif.start = pend_reg && !sif.busy && !sent_reg && issue_ok;
    assign sif.kind  = kind_w;
    assign sif.wdata = (kind_w == nand_host_pkg::KIND_CMD)  ? {8'h00, code_w} :
                       (kind_w == nand_host_pkg::KIND_ADDR) ?
                           ((acnt_reg == 2'd0) ? {8'h00, addr_reg[7:0]} :
                            (acnt_reg == 2'd1) ? {8'h00, addr_reg[16:9]} :
                                                 {8'h00, 1'b0, addr_reg[23:17]}) : wdata_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= 32'h0000_0000;
            addr_reg    <= 32'h0000_0000;
            wdata_reg   <= 16'h0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (aw_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_hit ? 2'b00 : 2'b10;
                if (s_axi_awaddr == nand_host_pkg::REG_CTRL)  ctrl_reg  <= s_axi_wdata;
                if (s_axi_awaddr == nand_host_pkg::REG_ADDR)  addr_reg  <= {8'h00, s_axi_wdata[23:0]};
                if (s_axi_awaddr == nand_host_pkg::REG_WDATA) wdata_reg <= s_axi_wdata[15:0];
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= map_hit(s_axi_araddr) ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // A write to the control register with the go bit queues one cycle (or three for addresses).
    assign issue_reg = aw_take && s_axi_awaddr == nand_host_pkg::REG_CTRL && s_axi_wdata[31];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_reg     <= 1'b0;
            acnt_reg     <= 2'd0;
            sent_reg     <= 1'b0;
            refused_reg  <= 1'b0;
            dev_busy_reg <= 1'b0;
            last_cmd_reg <= 8'h00;
        end else begin
            if (issue_reg) begin
                refused_reg <= 1'b0;
                pend_reg    <= 1'b1;
                acnt_reg    <= 2'd0;
            end
            if (sif.start) sent_reg <= 1'b1;
            if (pend_reg && !sent_reg && !sif.busy && !issue_ok) begin
                pend_reg    <= 1'b0;
                refused_reg <= 1'b1;
            end
            if (sif.done) begin
                sent_reg <= 1'b0;
                if (kind_w == nand_host_pkg::KIND_CMD) begin
                    last_cmd_reg <= code_w;
                    dev_busy_reg <= code_w == nand_host_pkg::CMD_PROGRAM ||
                                    code_w == nand_host_pkg::CMD_ERASE_START;
                end
                if (kind_w == nand_host_pkg::KIND_ADDR &&
                    acnt_reg != 2'(nand_host_pkg::ADDR_CYCLES - 1)) begin
                    acnt_reg <= acnt_reg + 2'd1;
                end else begin
                    pend_reg <= 1'b0;
                end
            end else if (dev_busy_reg && ready_busy_n && !sif.busy) begin
                dev_busy_reg <= 1'b0;
            end
        end
    end

    strobe_driver #(.WIDE(WIDE)) u_drv (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .sq             (sif.drv),
        .cmd_latch      (cmd_latch),
        .addr_latch     (addr_latch),
        .write_strobe_n (write_strobe_n),
        .read_strobe_n  (read_strobe_n),
        .io_out         (io_out),
        .io_oe          (io_oe),
        .io_in          (io_in)
    );
endmodule : nand_host
`default_nettype wire

// >>> logic/nand_host_pkg.sv
// Package with command codes, address layout, geometry, timing and register map of the NAND host.
package nand_host_pkg;
    localparam logic [7:0] CMD_READ_FIRST  = 8'h00;
    localparam logic [7:0] CMD_READ_SECOND = 8'h01;
    localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
    localparam logic [7:0] CMD_DATA_LOAD   = 8'h80;
    localparam logic [7:0] CMD_PROGRAM     = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_START = 8'hd0;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_IDENT       = 8'h90;
    localparam logic [7:0] CMD_RESET       = 8'hff;

    // Page geometry for the 8-bit and 16-bit variants.
    localparam int PAGE_BYTES_X8   = 528;
    localparam int MAIN_BYTES_X8   = 512;
    localparam int SPARE_BYTES_X8  = 16;
    localparam int PAGE_WORDS_X16  = 264;
    localparam int MAIN_WORDS_X16  = 256;
    localparam int SPARE_WORDS_X16 = 8;
    localparam int PAGES_PER_BLOCK = 32;
    localparam int BLOCKS          = 1024;
    localparam int HALF_COLUMN     = 256;

    // Address cycle layout: column A0..A7, page A9..A23 with A9..A13 page-in-block, A14..A23 block.
    localparam int ADDR_CYCLES     = 3;
    localparam int PAGE_IN_BLK_W   = 5;
    localparam int BLOCK_W         = 10;
    localparam int PAGE_ADDR_W     = 15;

    // Strobe phase lengths in ns and in clock cycles at 125 MHz.
    localparam int CLK_PERIOD_NS   = 8;
    localparam int STROBE_LOW_NS   = 24;
    localparam int STROBE_HIGH_NS  = 24;
    localparam int LOW_CYCLES      = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYCLES     = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AXI4-Lite register offsets.
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_ADDR    = 5'h04;
    localparam logic [4:0] REG_WDATA   = 5'h08;
    localparam logic [4:0] REG_RDATA   = 5'h0c;
    localparam logic [4:0] REG_STATUS  = 5'h10;

    // Control register fields.
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_KIND_LSB = 8;
    localparam int CTRL_WP_BIT   = 12;

    typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_WDATA, KIND_RDATA} kind_t;
endpackage : nand_host_pkg

// >>> logic/strobe_if.sv
// Interface joining the cycle sequencer to the pin driver.
`timescale 1ns/100ps
`default_nettype none
interface strobe_if;
    logic                          start;
    nand_host_pkg::kind_t          kind;
    logic [15:0]                   wdata;
    logic                          done;
    logic [15:0]                   rdata;
    logic                          busy;
    modport seq (output start, output kind, output wdata, input done, input rdata, input busy);
    modport drv (input start, input kind, input wdata, output done, output rdata, output busy);
endinterface : strobe_if
`default_nettype wire

// >>> logic/strobe_driver.sv
// Pin driver producing one framed command, address, write-data or read-data cycle.
`timescale 1ns/100ps
`default_nettype none
module strobe_driver #(
    parameter int WIDE = 0
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Sequencer side
    strobe_if.drv     sq,
    // Pins
    output logic        cmd_latch,
    output logic        addr_latch,
    output logic        write_strobe_n,
    output logic        read_strobe_n,
    output logic [15:0] io_out,
    output logic        io_oe,
    input  wire logic [15:0] io_in
);
    typedef enum {S_IDLE, S_LOW, S_HIGH} phase_t;
    phase_t     st_reg;
    logic [3:0] cnt_reg;
    nand_host_pkg::kind_t kind_reg;
    logic       rd_w;

    assign rd_w    = (kind_reg == nand_host_pkg::KIND_RDATA);
    assign sq.busy = (st_reg != S_IDLE);

    always_ff @(posedge aclk) begin
        sq.done <= 1'b0;
        if (!aresetn) begin
            st_reg         <= S_IDLE;
            cnt_reg        <= 4'h0;
            kind_reg       <= nand_host_pkg::KIND_CMD;
            cmd_latch      <= 1'b0;
            addr_latch     <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n  <= 1'b1;
            io_out         <= 16'h0000;
            io_oe          <= 1'b0;
            sq.rdata       <= 16'h0000;
        end else begin
            unique case (st_reg)
                S_IDLE: if (sq.start) begin
                    kind_reg <= sq.kind;
                    cmd_latch  <= (sq.kind == nand_host_pkg::KIND_CMD);
                    addr_latch <= (sq.kind == nand_host_pkg::KIND_ADDR);
                    io_out <= (WIDE != 0 && sq.kind != nand_host_pkg::KIND_WDATA) ?
                              {8'h00, sq.wdata[7:0]} : sq.wdata;
                    io_oe  <= (sq.kind != nand_host_pkg::KIND_RDATA);
                    write_strobe_n <= (sq.kind == nand_host_pkg::KIND_RDATA);
                    read_strobe_n  <= (sq.kind != nand_host_pkg::KIND_RDATA);
                    cnt_reg <= 4'(nand_host_pkg::LOW_CYCLES - 1);
                    st_reg  <= S_LOW;
                end
                S_LOW: if (cnt_reg != 4'h0) begin
                    cnt_reg <= cnt_reg - 4'h1;
                end else begin
                    if (rd_w) sq.rdata <= WIDE != 0 ? io_in : {8'h00, io_in[7:0]};
                    write_strobe_n <= 1'b1;
                    read_strobe_n  <= 1'b1;
                    cnt_reg <= 4'(nand_host_pkg::HIGH_CYCLES - 1);
                    st_reg  <= S_HIGH;
                end
                S_HIGH: if (cnt_reg != 4'h0) begin
                    cnt_reg <= cnt_reg - 4'h1;
                end else begin
                    cmd_latch  <= 1'b0;
                    addr_latch <= 1'b0;
                    io_oe      <= 1'b0;
                    sq.done    <= 1'b1;
                    st_reg     <= S_IDLE;
                end
            endcase
        end
    end
endmodule : strobe_driver
`default_nettype wire

// >>> tb/nand_host_checker.sv
// Checker watching the host's flash pins and its write handshake.
`timescale 1ns/100ps
`default_nettype none
module nand_host_checker #(
    parameter int WIDE = 0
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write handshake
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    // Flash pins
    input wire logic        chip_select_n,
    input wire logic        cmd_latch,
    input wire logic        addr_latch,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [15:0] io_out,
    input wire logic        io_oe,
    input wire logic        ready_busy_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       ws_q_reg;
    logic [1:0] acnt_reg;
    wire        wr_rise = write_strobe_n && !ws_q_reg;
    wire        cmd_end = wr_rise && cmd_latch;
    wire [7:0]  code = io_out[7:0];
    // Address cycles since the last command, so the third one can be told apart.
    wire [1:0]  acnt_next = cmd_end ? 2'h0 : (wr_rise && addr_latch) ? acnt_reg + 2'h1 : acnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ws_q_reg <= 1'b1;
            acnt_reg <= 2'h0;
        end else begin
            ws_q_reg <= write_strobe_n;
            acnt_reg <= acnt_next;
        end
    end
    a_latch_excl: assert property (!(cmd_latch && addr_latch))
        else $error("both latch lines high");
    a_write_qual: assert property (!write_strobe_n |-> !chip_select_n && read_strobe_n && io_oe)
        else $error("write strobe without select or drive");
    a_low_phase: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
        else $error("write strobe low phase length wrong");
    a_edge_hold: assert property (wr_rise |-> $stable(io_out) && $stable(cmd_latch) && $stable(addr_latch))
        else $error("bus or latch moved at rising write strobe");
    a_upper_low: assert property (!write_strobe_n && (cmd_latch || addr_latch) |-> io_out[15:8] == 8'h00)
        else $error("upper byte not low in command or address");
    a_third_top: assert property (wr_rise && addr_latch && acnt_reg == 2'h2 |-> !io_out[7])
        else $error("third address cycle top bit high");
    a_read_float: assert property (!read_strobe_n |-> !io_oe && !cmd_latch && !addr_latch && write_strobe_n)
        else $error("host drives or latches during read");
    a_code_set: assert property (cmd_end |-> code inside {8'h00, 8'h01, 8'h50, 8'h80, 8'h10, 8'h60, 8'hd0,
            8'h70, 8'h90, 8'hff})
        else $error("undefined command code sent");
    // The device goes busy at the very strobe edge that starts a program or erase, so look one cycle back.
    a_busy_cmds: assert property (cmd_end && !$past(ready_busy_n) |-> code inside {8'h70, 8'hff})
        else $error("command other than status or reset while busy");
    a_wide_second: assert property (WIDE != 0 && cmd_end |-> code != 8'h01)
        else $error("second half read sent to wide device");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    c_command: cover property (cmd_end);
    c_third_addr: cover property (wr_rise && addr_latch && acnt_reg == 2'h2);
    c_read: cover property ($fell(read_strobe_n));
endmodule : nand_host_checker
bind nand_host nand_host_checker #(.WIDE(WIDE)) chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n, .io_out, .io_oe,
    .ready_busy_n);
`default_nettype wire

// >>> tb/nand_dev_model.sv
// Behavioural model of the small-page flash device behind the host pins.
`timescale 1ns/100ps
`default_nettype none
module nand_dev_model #(
    parameter int BUSY_CYC = 200
) (
    // Clock for the busy time
    input wire logic        aclk,
    // Host pins
    input wire logic        chip_select_n,
    input wire logic        cmd_latch,
    input wire logic        addr_latch,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic        write_protect_n,
    input wire logic [15:0] io_out,
    // Device outputs and observed state
    output logic [15:0]     io_in,
    output logic            ready_busy_n,
    output logic [7:0]      dev_cmd,
    output logic [8:0]      dev_col,
    output logic [14:0]     dev_page,
    output logic [15:0]     dev_wcnt
);
    int         busy_cnt = 0;
    logic [1:0] acyc = 2'h0;
    logic       half = 1'b0;
    logic       loaded = 1'b0;
    logic [7:0] dout = 8'h00;
    wire [7:0]  code = io_out[7:0];
    wire        busy = busy_cnt != 0;
    wire        prot = !write_protect_n;
    initial begin
        dev_cmd = 8'h00;
        dev_col = 9'h000;
        dev_page = 15'h0000;
        dev_wcnt = 16'h0000;
    end
    assign ready_busy_n = !busy;
    assign io_in = read_strobe_n ? {8'hff, ~dout} : {8'h00, dout};
    always @(posedge aclk) begin
        if (busy_cnt > 0) busy_cnt = busy_cnt - 1;
    end
    always @(posedge write_strobe_n) begin
        if (!chip_select_n && read_strobe_n) begin
            dev_wcnt = dev_wcnt + 16'h1;
            if (cmd_latch && !addr_latch && (!busy || code == 8'h70 || code == 8'hff)) begin
                if (code == 8'h00 || code == 8'h01) half = code[0];
                if (!prot && ((code == 8'h10 && dev_cmd == 8'h80 && loaded) || (code == 8'hd0 && dev_cmd == 8'h60)))
                    busy_cnt = BUSY_CYC;
                if (code == 8'hff) busy_cnt = 0;
                if (code == 8'h80) loaded = 1'b0;
                dev_cmd = code;
                acyc = 2'h0;
            end else if (addr_latch && !cmd_latch) begin
                case (acyc)
                    2'h0: dev_col = {half, code};
                    2'h1: dev_page[7:0] = code;
                    default: dev_page[14:8] = code[6:0];
                endcase
                acyc = acyc + 2'h1;
            end else if (!cmd_latch && !addr_latch && !prot) begin
                loaded = 1'b1;
            end
        end
    end
    always @(negedge read_strobe_n) begin
        if (!chip_select_n && write_strobe_n && !busy) begin
            dout = dev_col[7:0] ^ {dev_col[8], 7'h00};
            dev_col = dev_col + 9'h001;
        end
    end
endmodule : nand_dev_model
`default_nettype wire

// >>> tb/nand_host_tb.sv
// Self-checking bench for the NAND host controller with the device model.
`timescale 1ns/100ps
`default_nettype none
module nand_host_tb;
    typedef struct packed {logic [7:0] code; logic taken;} row_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready_busy_n;
    wire logic chip_select_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_protect_n, io_oe;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [15:0] io_out, io_in, dev_wcnt;
    wire logic [7:0] dev_cmd;
    wire logic [8:0] dev_col;
    wire logic [14:0] dev_page;
    logic aw_hs, w_hs, b_hs, ar_hs, r_hs;
    logic [31:0] rd_q, d;
    logic [1:0] resp_q, r;
    logic [15:0] n;
    int err_total = 0, checks_done = 0, cyc = 0;
    row_t rows [9] = '{{8'h00, 1'b1}, {8'h01, 1'b1}, {8'h50, 1'b1}, {8'h90, 1'b1}, {8'h70, 1'b1},
        {8'h80, 1'b1}, {8'h60, 1'b1}, {8'hff, 1'b1}, {8'h33, 1'b0}};
    nand_host #(.WIDE(0)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n,
        .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n, .write_protect_n, .io_out, .io_oe, .io_in,
        .ready_busy_n);
    nand_dev_model #(.BUSY_CYC(200)) dev_u (.aclk, .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n,
        .read_strobe_n, .write_protect_n, .io_out, .io_in, .ready_busy_n, .dev_cmd, .dev_col, .dev_page, .dev_wcnt);
    initial forever #4 aclk = ~aclk;
    // Handshakes are captured at the edge itself so the tasks read them free of races.
    always @(posedge aclk) begin
        aw_hs <= s_axi_awvalid && s_axi_awready;
        w_hs <= s_axi_wvalid && s_axi_wready;
        b_hs <= s_axi_bvalid && s_axi_bready;
        ar_hs <= s_axi_arvalid && s_axi_arready;
        r_hs <= s_axi_rvalid && s_axi_rready;
        rd_q <= s_axi_rdata;
        resp_q <= s_axi_bvalid ? s_axi_bresp : s_axi_rresp;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask : tick
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            tick(1);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end while (!b_hs);
        s_axi_bready <= 1'b0;
        r = resp_q;
    endtask : axi_wr
    task automatic axi_rd(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            tick(1);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end while (!r_hs);
        s_axi_rready <= 1'b0;
        d = rd_q;
        r = resp_q;
    endtask : axi_rd
    task automatic go(input logic [7:0] code, input logic [1:0] kind, input logic wp);
        axi_wr(nand_host_pkg::REG_CTRL, {1'b1, 18'h0, wp, 2'h0, kind, code});
        tick(40);
        axi_rd(nand_host_pkg::REG_STATUS);
    endtask : go
    task automatic wait_ready;
        for (int k = 0; k < 60 && d[0] !== 1'b1; k++) begin
            tick(8);
            axi_rd(nand_host_pkg::REG_STATUS);
        end
    endtask : wait_ready
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        foreach (rows[i]) begin
            n = dev_wcnt;
            go(rows[i].code, 2'h0, 1'b1);
            cmp(32'(dev_wcnt), 32'(n) + 32'(rows[i].taken));
            cmp(32'(d[1]), 32'(!rows[i].taken));
            if (rows[i].taken) cmp({24'h0, dev_cmd}, {24'h0, rows[i].code});
            if (rows[i].taken) cmp({24'h0, d[9:2]}, {24'h0, rows[i].code});
        end
        $display("test command table done");
        axi_wr(nand_host_pkg::REG_ADDR, 32'hffff_ffff);
        go(8'h00, 2'h0, 1'b1);
        go(8'h00, 2'h1, 1'b1);
        cmp(32'(dev_page), 32'h7fff);
        cmp(32'(dev_col), 32'h0ff);
        go(8'h00, 2'h3, 1'b1);
        go(8'h00, 2'h3, 1'b1);
        axi_rd(nand_host_pkg::REG_RDATA);
        cmp({24'h0, d[7:0]}, 32'h80);
        axi_wr(nand_host_pkg::REG_ADDR, 32'h0000_00a5);
        go(8'h01, 2'h0, 1'b1);
        go(8'h00, 2'h1, 1'b1);
        cmp(32'(dev_col), 32'h1a5);
        cmp(32'(dev_page), 32'h0);
        go(8'h00, 2'h3, 1'b1);
        axi_rd(nand_host_pkg::REG_RDATA);
        cmp({24'h0, d[7:0]}, 32'h25);
        $display("test address and read done");
        go(8'h80, 2'h0, 1'b0);
        go(8'h00, 2'h2, 1'b0);
        go(8'h10, 2'h0, 1'b0);
        cmp(32'({write_protect_n, d[0]}), 32'h1);
        go(8'h80, 2'h0, 1'b1);
        go(8'h00, 2'h2, 1'b1);
        go(8'h10, 2'h0, 1'b1);
        cmp(32'(d[0]), 32'h0);
        n = dev_wcnt;
        go(8'h00, 2'h0, 1'b1);
        cmp(32'({dev_wcnt, d[1]}), {15'h0, n, 1'b1});
        go(8'h70, 2'h0, 1'b1);
        cmp(32'(dev_wcnt), 32'(n) + 32'h1);
        wait_ready();
        go(8'h60, 2'h0, 1'b1);
        go(8'hd0, 2'h0, 1'b1);
        cmp(32'(d[0]), 32'h0);
        wait_ready();
        cmp(32'(d[0]), 32'h1);
        $display("test protect and busy done");
        axi_wr(5'h1c, 32'h1234_5678);
        cmp(32'(r), 32'h2);
        axi_rd(5'h1c);
        cmp({d[29:0], r}, 32'h2);
        aresetn <= 1'b0;
        tick(2);
        cmp(32'({write_strobe_n, read_strobe_n, cmd_latch, addr_latch, io_oe, write_protect_n}), 32'h30);
        aresetn <= 1'b1;
        tick(2);
        $display("test unmapped and reset done");
        report_and_stop();
    end
endmodule : nand_host_tb
`default_nettype wire
